// [hdl/nv_store_pkg.sv]
// Package for the non-volatile byte store controller: data-memory map, control
// field layout, reset values and cycle counts.
// Assumes a byte-wide special-function data bus with a 9-bit address (sector bit plus byte).
package nv_store_pkg;

   // ------------------------------------------------------------
   // Store geometry
   // ------------------------------------------------------------
   localparam int NV_DEPTH = 64;
   localparam int NV_ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int BUS_ADDR_W = 9;

   // ------------------------------------------------------------
   // Direct data-memory map, sector 0 (sector bit is address bit 8)
   // ------------------------------------------------------------
   localparam logic [8:0] ADDR_INDIRECT_PORT1 = 9'h002;
   localparam logic [8:0] ADDR_POINTER1_LOW = 9'h003;
   localparam logic [8:0] ADDR_POINTER1_HIGH = 9'h004;
   localparam logic [8:0] ADDR_POINTER2_LOW = 9'h005;
   localparam logic [8:0] ADDR_POINTER2_HIGH = 9'h006;
   localparam logic [8:0] ADDR_NV_BYTE_ADDRESS = 9'h01e;
   localparam logic [8:0] ADDR_NV_BYTE_DATA = 9'h01f;

   // ------------------------------------------------------------
   // Control register, reached only through pointer 1
   // ------------------------------------------------------------
   localparam logic [7:0] NV_CONTROL_OFFSET = 8'h40;
   localparam logic [7:0] NV_CONTROL_SECTOR = 8'h01;
   localparam logic [15:0] NV_CONTROL_TARGET = {NV_CONTROL_SECTOR, NV_CONTROL_OFFSET};

   // ------------------------------------------------------------
   // Control fields and reset values
   // ------------------------------------------------------------
   localparam int WRITE_ENABLE_BIT = 3;
   localparam int WRITE_TRIGGER_BIT = 2;
   localparam int READ_ENABLE_BIT = 1;
   localparam int READ_TRIGGER_BIT = 0;
   localparam logic [7:0] NV_CONTROL_RESET = 8'h00;
   localparam logic [7:0] NV_BYTE_ADDRESS_RESET = 8'h00;
   localparam logic [7:0] NV_BYTE_DATA_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ------------------------------------------------------------
   // Cycle counts (no duration is fixed for either cycle)
   // ------------------------------------------------------------
   localparam int TIMER_W = 12;
   localparam int READ_CYCLES_DEFAULT = 4;
   localparam int WRITE_CYCLES_DEFAULT = 1000;

endpackage

// [hdl/nv_cycle_timer.sv]
// Cycle timer that paces one read or write of the byte store.
// Assumes start arrives only while idle and cycles is at least one.
`timescale 1ns/10ps
module nv_cycle_timer #(
   parameter int WIDTH = nv_store_pkg::TIMER_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic [WIDTH-1:0] cycles,
   // Status
   output logic busy,
   output logic done
);
   import nv_store_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic busy;
      logic done;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (abort) begin
         next_s.busy = 1'b0;
         next_s.count = '0;
      end else if (start && !s.busy) begin
         next_s.busy = 1'b1;
         next_s.count = cycles;
      end else if (s.busy) begin
         if (s.count <= WIDTH'(1)) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.count = '0;
         end else begin
            next_s.count = s.count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign done = s.done;
endmodule

// [hdl/nv_store_ctrl.sv]
// Controller for a 64-byte non-volatile data store reached through address,
// data and control registers on the processor's byte-wide data bus.
// Assumes one bus access per cycle, synchronous inputs, and that the interrupt
// controller handles the vector request, stack and flag service outside.
//
// Contract
// - Address register holds six bits; the top two read as zero.
// - Eight-bit data register holds write byte or read result, resets zero.
// - Write trigger is ignored unless write enable was already set.
// - Write trigger clears itself when the write cycle ends.
// - Read trigger is ignored unless read enable was already set.
// - Read trigger clears at read end; fetched byte then sits in data.
// - Read data stays in the data register until the next operation.
// - Write enable low blocks every write; it resets low.
// - Read enable low blocks every read; it resets low.
// - Write cycles are timed by their own timer, not software cycles.
// - Write end sets the write-done flag and the shared request flag.
// - Vector only with all three enables set and stack not full.
// - Servicing clears only the shared flag; software clears write-done.
// - Both pointer pairs reset to zero, leaving control unreachable.
// - Store holds 64 bytes of eight bits, one byte per operation.
`timescale 1ns/10ps
module nv_store_ctrl #(
   parameter int DEPTH = nv_store_pkg::NV_DEPTH,
   parameter int READ_CYCLES = nv_store_pkg::READ_CYCLES_DEFAULT,
   parameter int WRITE_CYCLES = nv_store_pkg::WRITE_CYCLES_DEFAULT
) (
   // Clock, reset and freeze
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Data-memory bus
   input wire logic [nv_store_pkg::BUS_ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [nv_store_pkg::DATA_W-1:0] bus_wdata,
   output logic [nv_store_pkg::DATA_W-1:0] bus_rdata,
   // Interrupt side
   input wire logic global_irq_enable,
   input wire logic write_done_irq_enable,
   input wire logic multi_irq_enable,
   input wire logic stack_full,
   input wire logic irq_serviced,
   input wire logic write_done_irq_clear,
   output logic write_done_irq_flag,
   output logic multi_irq_flag,
   output logic irq_request,
   // Power mode and status
   input wire logic sleep_mode,
   output logic nv_busy
);
   import nv_store_pkg::*;

   // ------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } op_state_t;

   typedef struct packed {
      op_state_t fsm;
      logic [NV_ADDR_W-1:0] byte_addr;
      logic [DATA_W-1:0] byte_data;
      logic write_enable_bit;
      logic write_trigger;
      logic read_enable_bit;
      logic read_trigger;
      logic [7:0] pointer1_low;
      logic [7:0] pointer1_high;
      logic [7:0] pointer2_low;
      logic [7:0] pointer2_high;
      logic [NV_ADDR_W-1:0] op_addr;
      logic [DATA_W-1:0] op_data;
      logic done_flag;
      logic multi_flag;
      logic [DATA_W-1:0] rdata;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;

   // The store itself keeps no reset: its contents survive power cycles
   logic [DATA_W-1:0] mem [0:DEPTH-1];
   logic mem_we;
   logic timer_start;
   logic timer_abort;
   logic [TIMER_W-1:0] timer_cycles;
   logic timer_busy;
   logic timer_done;
   logic control_hit;
   logic [7:0] control_view;
   // Direct register selects
   logic hit_byte_address;
   logic hit_byte_data;
   logic hit_pointer1_low;
   logic hit_pointer1_high;
   logic hit_pointer2_low;
   logic hit_pointer2_high;

   // ------------------------------------------------------------
   // Cycle timer
   // ------------------------------------------------------------
   nv_cycle_timer #(
      .WIDTH(TIMER_W)
   ) i_nv_cycle_timer (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(timer_start),
      .abort(timer_abort),
      .cycles(timer_cycles),
      .busy(timer_busy),
      .done(timer_done)
   );

   // ------------------------------------------------------------
   // Direct decode
   // ------------------------------------------------------------
   // One decode per register keeps the write and read paths in step
   always_comb begin
      hit_byte_address = (bus_addr == ADDR_NV_BYTE_ADDRESS);
      hit_byte_data = (bus_addr == ADDR_NV_BYTE_DATA);
      hit_pointer1_low = (bus_addr == ADDR_POINTER1_LOW);
      hit_pointer1_high = (bus_addr == ADDR_POINTER1_HIGH);
      hit_pointer2_low = (bus_addr == ADDR_POINTER2_LOW);
      hit_pointer2_high = (bus_addr == ADDR_POINTER2_HIGH);
   end

   // ------------------------------------------------------------
   // Indirect decode and control view
   // ------------------------------------------------------------
   // Control appears only behind indirect port 1 with the pointer at its target
   always_comb begin
      control_hit = (bus_addr == ADDR_INDIRECT_PORT1) &&
         ({s.pointer1_high, s.pointer1_low} == NV_CONTROL_TARGET);
      control_view = NV_CONTROL_RESET;
      control_view[WRITE_ENABLE_BIT] = s.write_enable_bit;
      control_view[WRITE_TRIGGER_BIT] = s.write_trigger;
      control_view[READ_ENABLE_BIT] = s.read_enable_bit;
      control_view[READ_TRIGGER_BIT] = s.read_trigger;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      mem_we = 1'b0;
      timer_start = 1'b0;
      timer_abort = 1'b0;
      timer_cycles = '0;

      // Register writes
      if (bus_wr) begin
         if (hit_byte_address) begin
            next_s.byte_addr = bus_wdata[NV_ADDR_W-1:0];
         end
         if (hit_byte_data) begin
            next_s.byte_data = bus_wdata;
         end
         if (hit_pointer1_low) begin
            next_s.pointer1_low = bus_wdata;
         end
         if (hit_pointer1_high) begin
            next_s.pointer1_high = bus_wdata;
         end
         // Pointer 2 is plain storage; only pointer 1 reaches the control register
         if (hit_pointer2_low) begin
            next_s.pointer2_low = bus_wdata;
         end
         if (hit_pointer2_high) begin
            next_s.pointer2_high = bus_wdata;
         end
         if (control_hit) begin
            next_s.write_enable_bit = bus_wdata[WRITE_ENABLE_BIT];
            next_s.read_enable_bit = bus_wdata[READ_ENABLE_BIT];
            // Enables are judged on their old value, so one write cannot arm and fire
            if (s.fsm == ST_IDLE) begin
               if (bus_wdata[WRITE_TRIGGER_BIT] && s.write_enable_bit) begin
                  next_s.write_trigger = 1'b1;
                  next_s.fsm = ST_WRITE;
                  next_s.op_addr = s.byte_addr;
                  next_s.op_data = s.byte_data;
                  timer_start = 1'b1;
                  timer_cycles = TIMER_W'(WRITE_CYCLES);
               end else if (bus_wdata[READ_TRIGGER_BIT] && s.read_enable_bit) begin
                  next_s.read_trigger = 1'b1;
                  next_s.fsm = ST_READ;
                  next_s.op_addr = s.byte_addr;
                  timer_start = 1'b1;
                  timer_cycles = TIMER_W'(READ_CYCLES);
               end
            end
         end
      end

      // Cycle completion and abort on sleep
      unique case (s.fsm)
         ST_IDLE: begin
         end
         ST_READ: begin
            if (sleep_mode) begin
               // Early sleep loses the read; data register keeps its old byte
               timer_abort = 1'b1;
               next_s.read_trigger = 1'b0;
               next_s.fsm = ST_IDLE;
            end else if (timer_done) begin
               next_s.byte_data = mem[s.op_addr];
               next_s.read_trigger = 1'b0;
               next_s.fsm = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (sleep_mode) begin
               timer_abort = 1'b1;
               next_s.write_trigger = 1'b0;
               next_s.fsm = ST_IDLE;
            end else if (timer_done) begin
               mem_we = 1'b1;
               next_s.write_trigger = 1'b0;
               next_s.fsm = ST_IDLE;
            end
         end
      endcase

      // Flags: a set in the clearing cycle wins
      next_s.done_flag = (s.done_flag && !write_done_irq_clear) || mem_we;
      next_s.multi_flag = (s.multi_flag && !irq_serviced) || mem_we;

      // Registered read data
      if (bus_rd) begin
         if (hit_byte_address) begin
            next_s.rdata = {{(DATA_W-NV_ADDR_W){1'b0}}, s.byte_addr};
         end else if (hit_byte_data) begin
            next_s.rdata = s.byte_data;
         end else if (hit_pointer1_low) begin
            next_s.rdata = s.pointer1_low;
         end else if (hit_pointer1_high) begin
            next_s.rdata = s.pointer1_high;
         end else if (hit_pointer2_low) begin
            next_s.rdata = s.pointer2_low;
         end else if (hit_pointer2_high) begin
            next_s.rdata = s.pointer2_high;
         end else if (control_hit) begin
            next_s.rdata = control_view;
         end else begin
            next_s.rdata = UNMAPPED_READ;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s.fsm <= ST_IDLE;
         s.byte_addr <= NV_BYTE_ADDRESS_RESET[NV_ADDR_W-1:0];
         s.byte_data <= NV_BYTE_DATA_RESET;
         s.write_enable_bit <= NV_CONTROL_RESET[WRITE_ENABLE_BIT];
         s.write_trigger <= NV_CONTROL_RESET[WRITE_TRIGGER_BIT];
         s.read_enable_bit <= NV_CONTROL_RESET[READ_ENABLE_BIT];
         s.read_trigger <= NV_CONTROL_RESET[READ_TRIGGER_BIT];
         s.pointer1_low <= POINTER_RESET;
         s.pointer1_high <= POINTER_RESET;
         s.pointer2_low <= POINTER_RESET;
         s.pointer2_high <= POINTER_RESET;
         s.op_addr <= '0;
         s.op_data <= '0;
         s.done_flag <= 1'b0;
         s.multi_flag <= 1'b0;
         s.rdata <= UNMAPPED_READ;
      end else if (ce) begin
         s <= next_s;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && mem_we) begin
         mem[s.op_addr] <= s.op_data;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus_rdata = s.rdata;
   assign write_done_irq_flag = s.done_flag;
   assign multi_irq_flag = s.multi_flag;
   assign irq_request = global_irq_enable && write_done_irq_enable && multi_irq_enable &&
      s.multi_flag && !stack_full;
   // Busy also covers the edge between timer end and the state's return to idle
   assign nv_busy = (s.fsm != ST_IDLE) || timer_busy;
endmodule

// [sim/nv_store_ctrl_props.sv]
// Port-level assertions for the byte store controller.
// Assumes a bind onto nv_store_ctrl with the same cycle counts.
`timescale 1ns/10ps
module nv_store_ctrl_props
   import nv_store_pkg::*;
#(
   parameter int READ_CYCLES = nv_store_pkg::READ_CYCLES_DEFAULT,
   parameter int WRITE_CYCLES = nv_store_pkg::WRITE_CYCLES_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bus
   input wire logic [nv_store_pkg::BUS_ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [nv_store_pkg::DATA_W-1:0] bus_rdata,
   // Interrupt and status
   input wire logic global_irq_enable,
   input wire logic write_done_irq_enable,
   input wire logic multi_irq_enable,
   input wire logic stack_full,
   input wire logic irq_serviced,
   input wire logic write_done_irq_clear,
   input wire logic write_done_irq_flag,
   input wire logic multi_irq_flag,
   input wire logic irq_request,
   input wire logic sleep_mode,
   input wire logic nv_busy
);
   // Longest legal busy span, with one edge of slack
   localparam int BUSY_MAX = (WRITE_CYCLES > READ_CYCLES ? WRITE_CYCLES : READ_CYCLES) + 2;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_addr_top;
      ce && bus_rd && bus_addr == ADDR_NV_BYTE_ADDRESS |=> bus_rdata[7:6] == 2'h0;
   endproperty
   a_addr_top: assert property (p_addr_top) else $error("address top bits set");
   property p_rdata_hold;
      !bus_rd |=> $stable(bus_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_busy_cause;
      $rose(nv_busy) |-> $past(bus_wr) && $past(bus_addr) == ADDR_INDIRECT_PORT1;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
   // Counts running busy cycles, since a long write outlasts any delay range
   int busy_run;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_run <= 0;
      end else if (ce) begin
         busy_run <= nv_busy ? busy_run + 1 : 0;
      end
   end
   property p_busy_ends;
      busy_run <= BUSY_MAX;
   endproperty
   a_busy_ends: assert property (p_busy_ends) else $error("cycle never ends");
   property p_done_flags;
      $rose(write_done_irq_flag) |-> $fell(nv_busy) && multi_irq_flag;
   endproperty
   a_done_flags: assert property (p_done_flags) else $error("done flags wrong");
   property p_irq;
      irq_request == (global_irq_enable && write_done_irq_enable && multi_irq_enable
                      && multi_irq_flag && !stack_full);
   endproperty
   a_irq: assert property (p_irq) else $error("request mismatch");
   property p_clear_done;
      ce && write_done_irq_clear && !nv_busy |=> !write_done_irq_flag;
   endproperty
   a_clear_done: assert property (p_clear_done) else $error("done flag kept");
   property p_service;
      ce && irq_serviced && !nv_busy |=> !multi_irq_flag;
   endproperty
   a_service: assert property (p_service) else $error("shared flag kept");
   property p_sleep;
      ce && sleep_mode && nv_busy |=> !nv_busy;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not abort");
   c_done: cover property ($rose(write_done_irq_flag));
   c_req: cover property (irq_request);
   c_sleep: cover property (sleep_mode && nv_busy);
   c_freeze: cover property (!ce && nv_busy);
endmodule
bind nv_store_ctrl nv_store_ctrl_props #(.READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
   i_nv_store_ctrl_props (.clk, .rst, .ce, .bus_addr, .bus_wr, .bus_rd, .bus_rdata, .global_irq_enable,
   .write_done_irq_enable, .multi_irq_enable, .stack_full, .irq_serviced, .write_done_irq_clear,
   .write_done_irq_flag, .multi_irq_flag, .irq_request, .sleep_mode, .nv_busy);

// [sim/eeprom_data_access_control_test.sv]
// Self-checking bench for the byte store controller.
// Assumes short cycle counts; ce drops only in the freeze scenario.
`timescale 1ns/10ps
module eeprom_data_access_control_test;
   import nv_store_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
   logic clk = 1'h0, rst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0, sleep_mode = 1'h0, ce = 1'h1;
   logic global_irq_enable = 1'h0, write_done_irq_enable = 1'h0, multi_irq_enable = 1'h0;
   logic stack_full = 1'h0, irq_serviced = 1'h0, write_done_irq_clear = 1'h0, rd_pend = 1'h0;
   logic [8:0] bus_addr = 9'h000;
   logic [7:0] bus_wdata = 8'h00, d, ev;
   logic [7:0] dv[3];
   logic [5:0] addrs[3];
   wire logic [7:0] bus_rdata;
   wire logic write_done_irq_flag, multi_irq_flag, irq_request, nv_busy;
   int num_errors = 0, compares = 0, k;
   logic [7:0] exp_q[$];
   localparam logic [8:0] CTL = ADDR_INDIRECT_PORT1;
   localparam int RD_CYC = 2;
   localparam int WR_CYC = 5;
   nv_store_ctrl #(.READ_CYCLES(RD_CYC), .WRITE_CYCLES(WR_CYC)) i_nv_store_ctrl (.clk, .rst, .ce,
      .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .global_irq_enable,
      .write_done_irq_enable, .multi_irq_enable, .stack_full, .irq_serviced,
      .write_done_irq_clear, .write_done_irq_flag, .multi_irq_flag, .irq_request,
      .sleep_mode, .nv_busy);
   initial forever #2 clk = ~clk;
   // ------------------------------------------------------------
   // Bus tasks and read monitor
   // ------------------------------------------------------------
   task automatic acc(input logic [8:0] ad, input logic [7:0] dt, input logic w);
      @(negedge clk);
      bus_addr = ad;
      bus_wdata = dt;
      bus_wr = w;
      bus_rd = !w;
      @(negedge clk);
      bus_wr = 1'h0;
      bus_rd = 1'h0;
   endtask
   task automatic wr(input logic [8:0] ad, input logic [7:0] dt);
      acc(ad, dt, 1'h1);
   endtask
   task automatic rd(input logic [8:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      acc(ad, 8'h00, 1'h0);
   endtask
   task automatic end_sim;
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Bounded so a stuck trigger ends the run instead of hanging it
   task automatic wait_idle;
      for (k = 0; k < 50 && nv_busy === 1'h1; k++) @(negedge clk);
      if (k == 50) begin
         num_errors++;
         end_sim;
      end
   endtask
   // Read data is one cycle behind its strobe
   always @(posedge clk) begin
      if (rd_pend) begin
         ev = exp_q.pop_front();
         `CHK(bus_rdata, ev)
      end
      rd_pend <= bus_rd && !rst;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(71));
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'h0;
      rd(ADDR_NV_BYTE_ADDRESS, 8'h00);
      rd(ADDR_NV_BYTE_DATA, 8'h00);
      wr(CTL, 8'h08);
      rd(ADDR_POINTER2_HIGH, POINTER_RESET);
      wr(ADDR_POINTER1_LOW, 8'h40);
      wr(ADDR_POINTER1_HIGH, 8'h01);
      rd(ADDR_POINTER1_LOW, 8'h40);
      rd(9'h140, UNMAPPED_READ);
      rd(CTL, 8'h00);
      wr(CTL, 8'h04);
      `CHK(nv_busy, 1'h0)
      wr(CTL, 8'h01);
      `CHK(nv_busy, 1'h0)
      wr(ADDR_NV_BYTE_DATA, 8'h5a);
      rd(ADDR_NV_BYTE_DATA, 8'h5a);
      d = 8'($urandom);
      wr(ADDR_NV_BYTE_ADDRESS, d | 8'hc0);
      rd(ADDR_NV_BYTE_ADDRESS, {2'h0, d[5:0]});
      wr(ADDR_POINTER2_LOW, d);
      rd(ADDR_POINTER2_LOW, d);
      addrs = '{6'h00, 6'h3f, 6'($urandom % 62 + 1)};
      for (int i = 0; i < 3; i++) begin
         dv[i] = 8'($urandom);
         wr(ADDR_NV_BYTE_ADDRESS, {2'h0, addrs[i]});
         wr(ADDR_NV_BYTE_DATA, dv[i]);
         global_irq_enable = 1'h0;
         wr(CTL, 8'h08);
         wr(CTL, 8'h0c);
         `CHK(nv_busy, 1'h1)
         global_irq_enable = 1'h1;
         wait_idle;
         `CHK(k, WR_CYC + 1)
         rd(CTL, 8'h08);
         `CHK(write_done_irq_flag, 1'h1)
         `CHK(multi_irq_flag, 1'h1)
         for (int j = 0; j < 16; j++) begin
            @(negedge clk);
            {global_irq_enable, write_done_irq_enable, multi_irq_enable, stack_full} = 4'(j);
            #1 `CHK(irq_request, (j == 14))
         end
         @(negedge clk) irq_serviced = 1'h1;
         @(negedge clk) irq_serviced = 1'h0;
         `CHK(multi_irq_flag, 1'h0)
         `CHK(write_done_irq_flag, 1'h1)
         write_done_irq_clear = 1'h1;
         @(negedge clk) write_done_irq_clear = 1'h0;
         `CHK(write_done_irq_flag, 1'h0)
         wr(ADDR_NV_BYTE_DATA, ~dv[i]);
         wr(CTL, 8'h02);
         wr(CTL, 8'h03);
         wait_idle;
         `CHK(k, RD_CYC + 1)
         rd(CTL, 8'h02);
         rd(ADDR_NV_BYTE_DATA, dv[i]);
         rd(ADDR_NV_BYTE_DATA, dv[i]);
      end
      // Freeze in mid-read: the cycle resumes where it stopped
      wr(ADDR_NV_BYTE_DATA, ~dv[2]);
      wr(CTL, 8'h03);
      ce = 1'h0;
      repeat (3) @(negedge clk);
      `CHK(nv_busy, 1'h1)
      ce = 1'h1;
      wait_idle;
      `CHK(k, RD_CYC + 1)
      rd(ADDR_NV_BYTE_DATA, dv[2]);
      // Sleep in mid-write must leave the old byte in place
      wr(ADDR_NV_BYTE_ADDRESS, 8'h3f);
      wr(ADDR_NV_BYTE_DATA, ~dv[1]);
      global_irq_enable = 1'h0;
      wr(CTL, 8'h08);
      wr(CTL, 8'h0c);
      sleep_mode = 1'h1;
      @(negedge clk) sleep_mode = 1'h0;
      `CHK(nv_busy, 1'h0)
      `CHK(write_done_irq_flag, 1'h0)
      wr(CTL, 8'h02);
      wr(CTL, 8'h03);
      wait_idle;
      rd(ADDR_NV_BYTE_DATA, dv[1]);
      repeat (2) @(negedge clk);
      end_sim;
   end
endmodule
